// file: hw/uwc_pkg.sv
package uwc_pkg;
  // ****************
  // sizes and codes
  // ****************
  localparam int WIPER_W = 6;
  localparam logic [5:0] WIPER_MIN = 6'h00;
  localparam logic [5:0] WIPER_MAX = 6'h3F;
  localparam logic [5:0] WIPER_RST = 6'h00;
  localparam int NUM_HV_CMDS = 6;

  // ****************
  // timing
  // ****************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STEP_TIME_NS = 1000;
  localparam int STEP_CYC = (STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NV_WRITE_CYCLE_TIME_US = 5000;
  localparam int NV_WRITE_CYC_DEF = (NV_WRITE_CYCLE_TIME_US * 1000 + 3) / 4;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
  localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;

  // ****************
  // commands
  // ****************
  typedef enum logic [2:0] {
    UWC_DEC_UNLOCK = 3'b000,
    UWC_DEC_LOCK = 3'b001,
    UWC_INC_UNLOCK = 3'b010,
    UWC_INC_LOCK = 3'b011,
    UWC_WR_UNLOCK = 3'b100,
    UWC_WR_LOCK = 3'b101
  } uwc_cmd_type;

  typedef struct packed {
    uwc_cmd_type cmd;
    logic [WIPER_W-1:0] steps;
  } uwc_req_type;

  typedef struct packed {
    logic sel_n;
    logic sel_hv;
    logic updn;
  } uwc_pins_type;
endpackage

// file: hw/uwc_timer.sv
`timescale 1ns/10ps
module uwc_timer
  import uwc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [uwc_pkg::TMR_W-1:0] count,
  output logic done
);
  import uwc_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } uwc_tmr_state_type;

  uwc_tmr_state_type st_r;
  uwc_tmr_state_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (load)
    begin
      st_nxt.cnt = count;
    end
    else if (st_r.cnt != TMR_ZERO)
    begin
      st_nxt.cnt = st_r.cnt - TMR_ONE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign done = (st_r.cnt == TMR_ZERO) && !load;
endmodule // uwc_timer

// file: hw/uwc_ctrl.sv
`timescale 1ns/10ps
module uwc_ctrl
  import uwc_pkg::*;
#(
  parameter int NV_WRITE_CYC = uwc_pkg::NV_WRITE_CYC_DEF,
  parameter int STEP_CYCLES = uwc_pkg::STEP_CYC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request
  input wire logic req_valid,
  input wire uwc_pkg::uwc_req_type req,
  output logic req_ready,
  output logic done,
  // tracked device state
  output logic [uwc_pkg::WIPER_W-1:0] wiper_est,
  output logic lock_est,
  // pins
  output uwc_pkg::uwc_pins_type pins
);
  import uwc_pkg::*;

  // ****************
  // state
  // ****************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_RAISE = 3'b010,
    S_PULSE_HI = 3'b011,
    S_PULSE_LO = 3'b100,
    S_EXITLVL = 3'b101,
    S_DROP = 3'b110,
    S_BUSY = 3'b111
  } uwc_fsm_type;

  typedef struct packed {
    uwc_fsm_type fsm;
    uwc_req_type cur;
    logic [15:0] dly;
    logic [WIPER_W-1:0] left;
    logic [WIPER_W-1:0] wiper;
    logic lock;
    logic done;
    uwc_pins_type pins;
  } uwc_state_type;

  uwc_state_type st_r;
  uwc_state_type st_nxt;
  logic tmr_load;
  logic tmr_done;

  localparam logic [15:0] STEP_DLY = 16'(STEP_CYCLES);

  // saturating step, direction up toward terminal A
  function automatic logic [WIPER_W-1:0] step_wiper(input logic [WIPER_W-1:0] w,
                                                    input logic up);
    if (up)
    begin
      step_wiper = (w == WIPER_MAX) ? w : w + 6'h01;
    end
    else
    begin
      step_wiper = (w == WIPER_MIN) ? w : w - 6'h01;
    end
  endfunction

  function automatic logic is_up(input uwc_cmd_type c);
    is_up = (c == UWC_INC_UNLOCK) || (c == UWC_INC_LOCK);
  endfunction

  // updn level before entry; low means decrement
  function automatic logic entry_lvl(input uwc_cmd_type c);
    entry_lvl = (c != UWC_DEC_UNLOCK) && (c != UWC_DEC_LOCK);
  endfunction

  // updn level at exit
  function automatic logic exit_lvl(input uwc_cmd_type c);
    case (c)
      UWC_DEC_UNLOCK: exit_lvl = 1'b0;
      UWC_DEC_LOCK: exit_lvl = 1'b1;
      UWC_INC_UNLOCK: exit_lvl = 1'b1;
      UWC_INC_LOCK: exit_lvl = 1'b0;
      UWC_WR_UNLOCK: exit_lvl = 1'b1;
      UWC_WR_LOCK: exit_lvl = 1'b0;
      default: exit_lvl = 1'b1;
    endcase
  endfunction

  function automatic logic sets_lock(input uwc_cmd_type c);
    sets_lock = (c == UWC_DEC_LOCK) || (c == UWC_INC_LOCK) || (c == UWC_WR_LOCK);
  endfunction

  function automatic logic is_write(input uwc_cmd_type c);
    is_write = (c == UWC_WR_UNLOCK) || (c == UWC_WR_LOCK);
  endfunction

  // ****************
  // sequencer
  // ****************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    tmr_load = 1'b0;
    if (st_r.dly != 16'h0000)
    begin
      st_nxt.dly = st_r.dly - 16'h0001;
    end
    else
    begin
      case (st_r.fsm)
        S_IDLE:
        begin
          st_nxt.pins.sel_n = 1'b1;
          st_nxt.pins.sel_hv = 1'b0;
          if (req_valid)
          begin
            st_nxt.cur = req;
            st_nxt.left = is_write(req.cmd) ? 6'h00 : req.steps;
            st_nxt.pins.updn = entry_lvl(req.cmd);
            st_nxt.dly = STEP_DLY;
            st_nxt.fsm = S_SETUP;
          end
        end
        S_SETUP:
        begin
          st_nxt.pins.sel_hv = 1'b1;
          st_nxt.dly = STEP_DLY;
          st_nxt.fsm = S_RAISE;
        end
        S_RAISE:
        begin
          if (st_r.left != 6'h00)
          begin
            st_nxt.pins.updn = 1'b0;
            st_nxt.dly = STEP_DLY;
            st_nxt.fsm = S_PULSE_LO;
          end
          else
          begin
            st_nxt.fsm = S_EXITLVL;
          end
        end
        S_PULSE_LO:
        begin
          st_nxt.pins.updn = 1'b1;
          st_nxt.wiper = step_wiper(st_r.wiper, is_up(st_r.cur.cmd));
          st_nxt.left = st_r.left - 6'h01;
          st_nxt.dly = STEP_DLY;
          st_nxt.fsm = S_PULSE_HI;
        end
        S_PULSE_HI:
        begin
          st_nxt.fsm = (st_r.left != 6'h00) ? S_RAISE : S_EXITLVL;
        end
        S_EXITLVL:
        begin
          st_nxt.pins.updn = exit_lvl(st_r.cur.cmd);
          // low-to-high exit level is one more step edge
          if (!st_r.pins.updn && exit_lvl(st_r.cur.cmd))
          begin
            st_nxt.wiper = step_wiper(st_r.wiper, is_up(st_r.cur.cmd));
          end
          st_nxt.dly = STEP_DLY;
          st_nxt.fsm = S_DROP;
        end
        S_DROP:
        begin
          st_nxt.pins.sel_hv = 1'b0;
          st_nxt.lock = sets_lock(st_r.cur.cmd);
          tmr_load = 1'b1;
          st_nxt.fsm = S_BUSY;
        end
        S_BUSY:
        begin
          if (tmr_done)
          begin
            st_nxt.done = 1'b1;
            st_nxt.fsm = S_IDLE;
          end
        end
        default:
        begin
          st_nxt.fsm = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.fsm <= S_IDLE;
      st_r.wiper <= WIPER_RST;
      st_r.pins.sel_n <= 1'b1;
      st_r.pins.updn <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  uwc_timer uwc_timer_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(tmr_load),
    .count(TMR_W'(NV_WRITE_CYC)),
    .done(tmr_done)
  );

  assign req_ready = (st_r.fsm == S_IDLE) && (st_r.dly == 16'h0000);
  assign done = st_r.done;
  assign wiper_est = st_r.wiper;
  assign lock_est = st_r.lock;
  assign pins = st_r.pins;
endmodule // uwc_ctrl

// file: bench/uwc_ctrl_checker.sv
`timescale 1ns/10ps
module uwc_ctrl_checker
  import uwc_pkg::*;
#(
  parameter int NV_WRITE_CYC = 20,
  parameter int STEP_CYCLES = 2
)
(
  // clock, reset
  input wire logic ref_clk,
  input wire logic rst,
  // request
  input wire logic req_valid,
  input wire uwc_pkg::uwc_req_type req,
  input wire logic req_ready,
  input wire logic done,
  // state, pins
  input wire logic [uwc_pkg::WIPER_W-1:0] wiper_est,
  input wire logic lock_est,
  input wire uwc_pkg::uwc_pins_type pins
);
  logic hv_q, dir_r, ext_r;
  int cnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // entry level, exit level, cycles since exit
  always_ff @(posedge ref_clk)
  begin
    hv_q <= pins.sel_hv;
    if (pins.sel_hv && !hv_q) dir_r <= pins.updn;
    if (pins.sel_hv) ext_r <= pins.updn;
    if (rst) cnt_r <= 99999;
    else if (hv_q && !pins.sel_hv) cnt_r <= 1;
    else if (cnt_r < 99999) cnt_r <= cnt_r + 1;
  end
  property p_seln; pins.sel_n; endproperty
  a_seln: assert property (p_seln) else $error("select low");
  property p_entry; $rose(pins.sel_hv) |-> $stable(pins.updn); endproperty
  a_entry: assert property (p_entry) else $error("updn moved at entry");
  property p_step; $changed(wiper_est) |-> pins.sel_hv && wiper_est ==
    (dir_r ? $past(wiper_est) + 6'h01 : $past(wiper_est) - 6'h01); endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_sat; $changed(wiper_est) |-> $past(wiper_est) != (dir_r ? WIPER_MAX : WIPER_MIN);
  endproperty
  a_sat: assert property (p_sat) else $error("wiper wrapped");
  property p_busy; $rose(pins.sel_hv) |-> cnt_r >= NV_WRITE_CYC; endproperty
  a_busy: assert property (p_busy) else $error("command in write cycle");
  property p_donet; done |-> cnt_r >= NV_WRITE_CYC - 1 && cnt_r <= NV_WRITE_CYC + 4; endproperty
  a_donet: assert property (p_donet) else $error("done off time");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_lock; $fell(pins.sel_hv) |-> ##[0:2] lock_est == (ext_r != dir_r); endproperty
  a_lock: assert property (p_lock) else $error("bad lock");
  property p_rdy; pins.sel_hv || cnt_r < NV_WRITE_CYC |-> !req_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready during command");
endmodule // uwc_ctrl_checker
bind uwc_ctrl uwc_ctrl_checker #(.NV_WRITE_CYC(NV_WRITE_CYC), .STEP_CYCLES(STEP_CYCLES))
  uwc_ctrl_checker_inst (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .done(done), .wiper_est(wiper_est), .lock_est(lock_est), .pins(pins));

// file: bench/uwc_dev_model.sv
`timescale 1ns/10ps
module uwc_dev_model
  import uwc_pkg::*;
#(
  parameter int NV_WRITE_CYCLE_TIME = 20
)
(
  // clock, pins
  input wire logic ref_clk,
  input wire uwc_pkg::uwc_pins_type pins,
  // device state
  output logic [5:0] wiper = WIPER_RST,
  output logic [5:0] nv_wiper = WIPER_RST,
  output logic locked = 1'b0
);
  logic hv_q = 1'b0;
  logic ud_q = 1'b1;
  logic dir = 1'b0;
  int busy = 0;
  // six commands by entry and exit level; code 0 at terminal b
  always @(posedge ref_clk)
  begin
    if (busy > 0) busy--;
    else if (pins.sel_hv && !hv_q) dir = pins.updn;
    else if (pins.sel_hv && pins.updn && !ud_q)
    begin
      if (dir && wiper != WIPER_MAX) wiper++;
      if (!dir && wiper != WIPER_MIN) wiper--;
    end
    else if (!pins.sel_hv && hv_q)
    begin
      nv_wiper = wiper;
      locked = pins.updn != dir;
      busy = NV_WRITE_CYCLE_TIME;
    end
    hv_q = pins.sel_hv;
    ud_q = pins.updn;
  end
endmodule // uwc_dev_model

// file: bench/test_updown_wiper_hv_lock_control.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_updown_wiper_hv_lock_control;
  import uwc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  uwc_req_type req = '0;
  logic req_ready, done, lock_est, dev_lock, lexp;
  logic [5:0] wiper_est, dev_wiper, dev_nv, wexp;
  uwc_pins_type pins;
  int n_errors = 0;
  int compares = 0;
  logic [8:0] corner [7] = '{9'h002, 9'h0FF, 9'h084, 9'h045, 9'h040, 9'h100, 9'h140};
  uwc_ctrl #(.NV_WRITE_CYC(20), .STEP_CYCLES(2)) uwc_ctrl_inst (.ref_clk(ref_clk),
    .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done),
    .wiper_est(wiper_est), .lock_est(lock_est), .pins(pins));
  uwc_dev_model #(.NV_WRITE_CYCLE_TIME(20)) uwc_dev_model_inst (.ref_clk(ref_clk), .pins(pins),
    .wiper(dev_wiper), .nv_wiper(dev_nv), .locked(dev_lock));
  function automatic logic [5:0] nxt(input logic [5:0] w, input logic [8:0] r);
    int v;
    v = int'(w);
    if (r[8:7] == 2'b00) v = v - int'(r[5:0]);
    if (r[8:7] == 2'b01) v = v + int'(r[5:0]);
    // decrement with lock and no steps: the high exit level is a rising edge
    if (r[8:6] == 3'b001 && r[5:0] == 6'h00) v = v - 1;
    if (v < 0) v = 0;
    if (v > 63) v = 63;
    return 6'(v);
  endfunction
  task automatic results();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic run(input logic [8:0] r);
    int i;
    req = r;
    req_valid = 1'b1;
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(posedge ref_clk) #1;
    if (req_ready !== 1'b1)
    begin
      n_errors++;
      results();
    end
    @(posedge ref_clk) #1;
    req_valid = 1'b0;
    for (i = 0; i < 2000 && done !== 1'b1; i++) @(posedge ref_clk) #1;
    if (done !== 1'b1)
    begin
      n_errors++;
      results();
    end
    wexp = nxt(wexp, r);
    lexp = r[6];
    `CHK(req_ready, 1'b1);
    `CHK(wiper_est, wexp);
    `CHK(lock_est, lexp);
    `CHK(dev_wiper, wexp);
    `CHK(dev_nv, wexp);
    `CHK(dev_lock, lexp);
  endtask
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    logic [8:0] r;
    void'($urandom(49));
    wexp = 6'h00;
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    `CHK(pins, 3'b101);
    foreach (corner[k]) run(corner[k]);
    repeat (12)
    begin
      r = {3'($urandom_range(5, 0)), 6'($urandom_range(63, 0))};
      run(r);
    end
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    `CHK(wiper_est, 6'h00);
    `CHK(lock_est, 1'b0);
    `CHK(pins, 3'b101);
    `CHK(req_ready, 1'b1);
    results();
  end
endmodule // test_updown_wiper_hv_lock_control
